/* File: src/cpu_interrupt_vectoring.sv */
`timescale 1ns/100ps
`include "irq_vec_regs.svh"
module cpu_interrupt_vectoring #(
  parameter bit EDGE_AND_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu sequencer
  input wire logic instr_done,
  input wire logic software_trap,
  input wire logic return_from_handler,
  input wire irq_vec_pkg::cpu_ctx_t cpu_ctx,
  output logic seq_busy,
  output logic pc_load,
  output logic ctx_restore,
  output irq_vec_pkg::cpu_ctx_t ctx_out,
  output logic global_mask,
  output logic branch_if_line_high,
  // stack and vector memory
  output irq_vec_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // pins and peripheral flags
  input wire logic irq_pin_n,
  input wire logic [7:0] keyport_pin,
  input wire logic end_of_cycle_flag,
  input wire logic timer_overflow_flag,
  input wire logic periodic_tick_flag
);

  // ********************************************
  // state
  // ********************************************
  localparam irq_vec_pkg::core_t RST_Q = '{
    st: irq_vec_pkg::ST_VEC,
    vec: `VEC_RESET,
    ibit: 1'b1,
    sp: `SP_RESET,
    busy: 1'b1,
    irq_s1: 1'b1,
    irq_s2: 1'b1,
    irq_p: 1'b1,
    key_s1: 8'hff,
    key_s2: 8'hff,
    key_p: 8'hff,
    default: '0
  };

  irq_vec_pkg::core_t q;
  irq_vec_pkg::core_t d;
  logic ext_req;
  logic cmt_req;
  logic tmr_req;
  logic hw_ok;
  logic trap_now;
  logic ext_set;
  logic ext_clr;
  logic trap_clr;
  logic [5:0] sp_up;

  // ********************************************
  // request gathering
  // ********************************************
  always_comb begin
    ext_req = q.ext_pend & ~q.ext_mask;
    cmt_req = end_of_cycle_flag & q.eoc_ie;
    tmr_req = (timer_overflow_flag & q.tof_ie) | (periodic_tick_flag & q.rt_ie);
    hw_ok = ~q.ibit & (ext_req | cmt_req | tmr_req);
    trap_now = q.trap_pend | software_trap;
    // falling edges from the second sync stage only
    ext_set = (q.irq_p & ~q.irq_s2) | (|(q.key_p & ~q.key_s2 & q.key_en));
    // level mode re-arms while a line stays low
    if (EDGE_AND_LEVEL) begin
      ext_set = ext_set | ~q.irq_s2 | (|(~q.key_s2 & q.key_en));
    end
    sp_up = q.sp + 6'h01;
  end

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    d = q;
    ext_clr = 1'b0;
    trap_clr = 1'b0;
    d.mem.wr = 1'b0;
    d.mem.rd = 1'b0;
    d.pc_load = 1'b0;
    d.ctx_restore = 1'b0;
    // first stage feeds only the second stage
    d.irq_s1 = irq_pin_n;
    d.irq_s2 = q.irq_s1;
    d.irq_p = q.irq_s2;
    d.key_s1 = keyport_pin;
    d.key_s2 = q.key_s1;
    d.key_p = q.key_s2;
    d.line_high = q.irq_s2 & ~(|(~q.key_s2 & q.key_en));

    // register port
    d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `CTRL_OFS: d.rdata = {3'h0, q.rt_ie, q.tof_ie, q.eoc_ie, q.ext_mask, q.ibit};
        `KEY_EN_OFS: d.rdata = q.key_en;
        `STATUS_OFS: d.rdata = {3'h0, q.busy, q.trap_pend, tmr_req, cmt_req, ext_req};
        `SP_OFS: d.rdata = {2'h0, q.sp};
        `LINE_OFS: d.rdata = {7'h00, q.line_high};
        default: d.rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      if (reg_addr == `CTRL_OFS) begin
        d.ibit = reg_wdata[`CTRL_GMASK_BIT];
        d.ext_mask = reg_wdata[`CTRL_EXT_MASK_BIT];
        d.eoc_ie = reg_wdata[`CTRL_EOC_IE_BIT];
        d.tof_ie = reg_wdata[`CTRL_TOF_IE_BIT];
        d.rt_ie = reg_wdata[`CTRL_RT_IE_BIT];
      end
      if (reg_addr == `KEY_EN_OFS) begin
        d.key_en = reg_wdata;
      end
    end

    // sequencer; hardware mask updates override software writes
    unique case (q.st)
      irq_vec_pkg::ST_IDLE: begin
        if (return_from_handler) begin
          d.st = irq_vec_pkg::ST_PULL;
          d.cnt = 3'h0;
          d.busy = 1'b1;
        end else if ((instr_done | software_trap) & (hw_ok | trap_now)) begin
          d.st = irq_vec_pkg::ST_PUSH;
          d.cnt = 3'h0;
          d.busy = 1'b1;
          d.kind_trap = ~hw_ok;
          trap_clr = ~hw_ok;
          d.ctx = cpu_ctx;
          d.ctx.condition_flags_reg[`CCR_I_BIT] = q.ibit;
        end
      end
      irq_vec_pkg::ST_PUSH: begin
        d.mem.wr = 1'b1;
        d.mem.addr = {`STACK_PAGE, q.sp};
        d.sp = q.sp - 6'h01;
        unique case (q.cnt)
          3'h0: d.mem.wdata = q.ctx.pc[7:0];
          3'h1: d.mem.wdata = {3'h0, q.ctx.pc[12:8]};
          3'h2: d.mem.wdata = q.ctx.idx;
          3'h3: d.mem.wdata = q.ctx.acc;
          default: d.mem.wdata = {3'h0, q.ctx.condition_flags_reg};
        endcase
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == `PUSH_LAST) begin
          d.ibit = 1'b1;
          d.st = irq_vec_pkg::ST_VEC;
          d.cnt = 3'h0;
          if (q.kind_trap) begin
            d.vec = `VEC_TRAP;
          end else if (ext_req) begin
            d.vec = `VEC_EXT;
            ext_clr = 1'b1;
          end else if (cmt_req) begin
            d.vec = `VEC_CMT;
          end else begin
            d.vec = `VEC_TMR;
          end
        end
      end
      irq_vec_pkg::ST_VEC: begin
        d.cnt = q.cnt + 3'h1;
        unique case (q.cnt)
          3'h0: begin
            d.mem.rd = 1'b1;
            d.mem.addr = q.vec;
          end
          3'h1: begin
            d.mem.rd = 1'b1;
            d.mem.addr = q.vec | 14'h0001;
          end
          3'h2: d.ctx.pc[12:8] = mem_rdata[4:0];
          default: begin
            d.ctx.pc[7:0] = mem_rdata;
            d.pc_load = 1'b1;
            d.busy = 1'b0;
            d.st = irq_vec_pkg::ST_IDLE;
            d.cnt = 3'h0;
          end
        endcase
      end
      irq_vec_pkg::ST_PULL: begin
        d.cnt = q.cnt + 3'h1;
        if (q.cnt <= `PULL_ISSUE_LAST) begin
          d.mem.rd = 1'b1;
          d.mem.addr = {`STACK_PAGE, sp_up};
          d.sp = sp_up;
        end
        if (q.cnt >= `PULL_CAP_FIRST) begin
          unique case (q.cnt)
            3'h2: d.ctx.condition_flags_reg = mem_rdata[4:0];
            3'h3: d.ctx.acc = mem_rdata;
            3'h4: d.ctx.idx = mem_rdata;
            3'h5: d.ctx.pc[12:8] = mem_rdata[4:0];
            default: d.ctx.pc[7:0] = mem_rdata;
          endcase
        end
        if (q.cnt == `PULL_LAST) begin
          d.ibit = q.ctx.condition_flags_reg[`CCR_I_BIT];
          d.ctx_restore = 1'b1;
          d.pc_load = 1'b1;
          d.busy = 1'b0;
          d.st = irq_vec_pkg::ST_IDLE;
          d.cnt = 3'h0;
        end
      end
    endcase

    // set beats clear; a consumed trap clears itself
    d.ext_pend = ext_set | (q.ext_pend & ~ext_clr);
    d.trap_pend = trap_now & ~trap_clr;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  assign reg_rdata = q.rdata;
  assign seq_busy = q.busy;
  assign pc_load = q.pc_load;
  assign ctx_restore = q.ctx_restore;
  assign ctx_out = q.ctx;
  assign global_mask = q.ibit;
  assign branch_if_line_high = q.line_high;
  assign mem_req = q.mem;

  // ********************************************
  // build-time checks
  // ********************************************
  if (`PUSH_LAST != 3'h4) begin
    $error("stacking must cover five bytes");
  end
  if (`PULL_ISSUE_LAST != `PUSH_LAST) begin
    $error("pull must read back every stacked byte");
  end
  if (`PULL_LAST != (`PUSH_LAST + 3'h2)) begin
    $error("pull end must follow the last read data");
  end
  if (`VEC_LAST != 3'h3) begin
    $error("vector fetch needs two reads and two captures");
  end
  if ((`VEC_RESET | 14'h0001) != 14'h3fff) begin
    $error("reset pair must be the top pair");
  end
  if (`VEC_TRAP != (`VEC_RESET - 14'h0002)) begin
    $error("trap pair must sit below the reset pair");
  end
  if ((`VEC_RESET - `VEC_TMR) != 14'h0008) begin
    $error("vector table must span ten bytes");
  end
  if (`SP_RESET != '1) begin
    $error("stack must start at the window top");
  end

  // ********************************************
  // checks
  // ********************************************
  logic take;
  assign take = (q.st == irq_vec_pkg::ST_IDLE) && (d.st == irq_vec_pkg::ST_PUSH);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  latency_bound_a: assert property (take |-> ##10 q.pc_load) else $error("vector load late");
  mask_after_push_a: assert property (take |-> ##6 q.ibit) else $error("mask not set after stacking");
  push_five_a: assert property (take |-> ##2 q.mem.wr [*5] ##1 !q.mem.wr) else $error("push count wrong");
  pcl_first_a: assert property (take |-> ##2 (q.mem.wdata == $past(q.ctx.pc[7:0]))) else $error("low pc not first");
  stack_window_a: assert property (q.mem.wr |-> q.mem.addr[13:6] == `STACK_PAGE) else $error("stack outside window");
  mask_blocks_a: assert property ((q.st == irq_vec_pkg::ST_IDLE) && q.ibit && !software_trap && !q.trap_pend
    && !return_from_handler |=> q.st == irq_vec_pkg::ST_IDLE) else $error("masked request taken");
  ext_priority_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && !q.kind_trap
    && ext_req |=> q.vec == `VEC_EXT) else $error("external not first");
  ext_blocked_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && q.ext_mask
    |=> q.vec != `VEC_EXT) else $error("masked external vectored");
  reset_vector_a: assert property ($rose(rst_n) |-> ##1 q.mem.rd && (q.mem.addr == `VEC_RESET)) else
    $error("reset vector not fetched");
  trap_unmasked_a: assert property ((q.st == irq_vec_pkg::ST_IDLE) && software_trap && q.ibit
    && !return_from_handler |=> (q.st == irq_vec_pkg::ST_PUSH) && q.kind_trap) else $error("trap not taken");

  // mask, busy, vector choice, stack traffic, return and line test
  mask_reset_a: assert property ($rose(rst_n) |-> q.ibit) else $error("mask clear after reset");
  take_busy_a: assert property (take |=> q.busy) else $error("busy not raised");
  boundary_wait_a: assert property ((q.st == irq_vec_pkg::ST_IDLE) && !instr_done && !software_trap
    && !return_from_handler |=> q.st == irq_vec_pkg::ST_IDLE) else $error("taken mid instruction");
  busy_in_push_a: assert property ((q.st != irq_vec_pkg::ST_IDLE) |-> q.busy)
    else $error("sequence without busy");
  hw_before_trap_a: assert property ((q.st == irq_vec_pkg::ST_IDLE) && software_trap && hw_ok
    && !return_from_handler |=> (q.st == irq_vec_pkg::ST_PUSH) && !q.kind_trap && q.trap_pend)
    else $error("trap ahead of pending hw");
  trap_cleared_a: assert property (take && d.kind_trap |=> !q.trap_pend)
    else $error("served trap still pending");
  trap_vector_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && q.kind_trap
    |=> q.vec == `VEC_TRAP) else $error("trap vector wrong");
  cmt_vector_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && !q.kind_trap
    && !ext_req && cmt_req |=> q.vec == `VEC_CMT) else $error("modulator vector wrong");
  tmr_vector_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && !q.kind_trap
    && !ext_req && !cmt_req |=> q.vec == `VEC_TMR) else $error("timer vector wrong");
  ext_clear_a: assert property ((q.st == irq_vec_pkg::ST_PUSH) && (q.cnt == `PUSH_LAST) && !q.kind_trap
    && ext_req && !ext_set |=> !q.ext_pend) else $error("served external still pending");
  vector_window_a: assert property ((q.st == irq_vec_pkg::ST_VEC) && q.mem.rd
    |-> q.mem.addr >= `VEC_TMR) else $error("vector read outside table");
  vec_high_even_a: assert property ((q.st == irq_vec_pkg::ST_VEC) && (q.cnt == 3'h1)
    |-> q.mem.rd && !q.mem.addr[0]) else $error("high vector byte not even");
  load_not_busy_a: assert property (q.pc_load |-> !q.busy) else $error("load while busy");
  push_addr_a: assert property (take |-> ##2 (q.mem.addr == {`STACK_PAGE, $past(q.sp)}))
    else $error("first push address wrong");
  pull_first_a: assert property ((q.st == irq_vec_pkg::ST_PULL) && (q.cnt == 3'h0)
    |=> q.mem.rd && (q.mem.addr == {`STACK_PAGE, q.sp})) else $error("pull not pre-increment");
  pull_done_a: assert property ((q.st == irq_vec_pkg::ST_IDLE) && return_from_handler
    |-> ##8 q.ctx_restore) else $error("return restore late");
  restore_mask_a: assert property (q.ctx_restore |-> q.ibit == q.ctx.condition_flags_reg[`CCR_I_BIT])
    else $error("restored mask wrong");
  line_level_a: assert property (!q.irq_s2 |=> !q.line_high) else $error("line test ignores pin");

  hw_take_c: cover property (take && !d.kind_trap);
  trap_take_c: cover property (take && d.kind_trap);
  restore_c: cover property (q.ctx_restore);
  nested_c: cover property (take && !d.kind_trap && software_trap);
  reset_load_c: cover property ($rose(rst_n) ##4 q.pc_load);

endmodule : cpu_interrupt_vectoring

/* File: pkg/irq_vec_regs.svh */
`ifndef IRQ_VEC_REGS_SVH
`define IRQ_VEC_REGS_SVH

// ********************************************
// register offsets
// ********************************************
`define CTRL_OFS 8'h00
`define KEY_EN_OFS 8'h01
`define STATUS_OFS 8'h02
`define SP_OFS 8'h03
`define LINE_OFS 8'h04

// ********************************************
// control fields
// ********************************************
`define CTRL_GMASK_BIT 0
`define CTRL_EXT_MASK_BIT 1
`define CTRL_EOC_IE_BIT 2
`define CTRL_TOF_IE_BIT 3
`define CTRL_RT_IE_BIT 4

// ********************************************
// condition flags layout (H I N Z C)
// ********************************************
`define CCR_I_BIT 3

// ********************************************
// vector table and stack window
// ********************************************
`define VEC_RESET 14'h3ffe
`define VEC_TRAP 14'h3ffc
`define VEC_EXT 14'h3ffa
`define VEC_CMT 14'h3ff8
`define VEC_TMR 14'h3ff6
`define STACK_PAGE 8'h03
`define SP_RESET 6'h3f

// ********************************************
// sequence step counts
// ********************************************
`define PUSH_LAST 3'h4
`define VEC_LAST 3'h3
`define PULL_ISSUE_LAST 3'h4
`define PULL_CAP_FIRST 3'h2
`define PULL_LAST 3'h6
`define STACK_LATENCY 10

`endif

/* File: pkg/irq_vec_pkg.sv */
package irq_vec_pkg;

  // ********************************************
  // carriers
  // ********************************************
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [4:0] condition_flags_reg;
  } cpu_ctx_t;

  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mem_req_t;

  // ********************************************
  // sequencer state, gray along idle-push-vec
  // ********************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_VEC = 2'b11,
    ST_PULL = 2'b10
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [2:0] cnt;
    logic [5:0] sp;
    logic ibit;
    logic ext_mask;
    logic eoc_ie;
    logic tof_ie;
    logic rt_ie;
    logic [7:0] key_en;
    logic ext_pend;
    logic trap_pend;
    logic kind_trap;
    logic [13:0] vec;
    cpu_ctx_t ctx;
    logic irq_s1;
    logic irq_s2;
    logic irq_p;
    logic [7:0] key_s1;
    logic [7:0] key_s2;
    logic [7:0] key_p;
    mem_req_t mem;
    logic [7:0] rdata;
    logic pc_load;
    logic ctx_restore;
    logic busy;
    logic line_high;
  } core_t;

endpackage : irq_vec_pkg

/* File: bench/stack_vector_mem.sv */
`timescale 1ns/100ps
// ********************************************
// stack ram and vector rom seen by the sequencer
// ********************************************
module stack_vector_mem (
  // clock
  input wire logic sys_clk,
  // memory port
  input wire irq_vec_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:16383];

  // vector pairs: high byte even, low byte odd
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
    mem[14'h3ffe] = 8'h12;
    mem[14'h3fff] = 8'h34;
    mem[14'h3ffc] = 8'h05;
    mem[14'h3ffa] = 8'h06;
    mem[14'h3ff8] = 8'h07;
    mem[14'h3ff6] = 8'h08;
    mem_rdata = 8'h00;
  end

  // data only in the cycle after a read, scrambled otherwise
  always @(posedge sys_clk) begin
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd) mem_rdata <= mem[mem_req.addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule : stack_vector_mem

/* File: bench/cpu_interrupt_vectoring_bench.sv */
`timescale 1ns/100ps
`include "irq_vec_regs.svh"
module cpu_interrupt_vectoring_bench;
  logic sys_clk, rst_n, reg_wr, reg_rd, instr_done, software_trap, return_from_handler;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_rdata, keyport_pin;
  logic seq_busy, pc_load, ctx_restore, global_mask, branch_if_line_high;
  logic irq_pin_n, end_of_cycle_flag, timer_overflow_flag, periodic_tick_flag;
  irq_vec_pkg::cpu_ctx_t cpu_ctx, ctx_out;
  irq_vec_pkg::mem_req_t mem_req;
  int err_total, checks;

  always #2 sys_clk = ~sys_clk;

  cpu_interrupt_vectoring DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_done(instr_done), .software_trap(software_trap), .return_from_handler(return_from_handler),
    .cpu_ctx(cpu_ctx), .seq_busy(seq_busy), .pc_load(pc_load), .ctx_restore(ctx_restore),
    .ctx_out(ctx_out), .global_mask(global_mask), .branch_if_line_high(branch_if_line_high),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .irq_pin_n(irq_pin_n), .keyport_pin(keyport_pin),
    .end_of_cycle_flag(end_of_cycle_flag), .timer_overflow_flag(timer_overflow_flag),
    .periodic_tick_flag(periodic_tick_flag));

  stack_vector_mem mem_m (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ********************************************
  // helpers
  // ********************************************
  task stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd

  // bounded wait for the fetch pointer load, counting edges
  task wait_load(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (pc_load !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      stop_test();
    end
  endtask : wait_load

  // kind 0 boundary, 1 trap, 2 return
  task serve(input int kind, input logic [12:0] pc);
    int n;
    @(posedge sys_clk);
    instr_done <= (kind == 0);
    software_trap <= (kind == 1);
    return_from_handler <= (kind == 2);
    @(posedge sys_clk);
    instr_done <= 1'b0;
    software_trap <= 1'b0;
    return_from_handler <= 1'b0;
    wait_load(n);
    // count from the strobe cycle
    chk("latency", 34'(n + 1), (kind == 2) ? 34'd8 : 34'd10);
    chk("fetch pointer", ctx_out.pc, pc);
  endtask : serve

  task idle;
    @(posedge sys_clk);
    instr_done <= 1'b1;
    @(posedge sys_clk);
    instr_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("seq_busy", seq_busy, 1'b0);
  endtask : idle

  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    int n;
    sys_clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    instr_done = 0; software_trap = 0; return_from_handler = 0; irq_pin_n = 1;
    keyport_pin = 8'hff; end_of_cycle_flag = 0; timer_overflow_flag = 0; periodic_tick_flag = 0;
    err_total = 0; checks = 0;
    cpu_ctx = '{pc: 13'h0abc, acc: 8'h5a, idx: 8'hc3, condition_flags_reg: 5'h15};
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_load(n);
    chk("reset vector", ctx_out.pc, 13'h1234);
    chk("global_mask", global_mask, 1'b1);
    chk("line high", branch_if_line_high, 1'b1);
    rd(`CTRL_OFS, 8'h01);
    wr(`SP_OFS, 8'h00);
    rd(`SP_OFS, 8'h3f);
    rd(8'h10, 8'h00);
    wr(`CTRL_OFS, 8'h09);
    timer_overflow_flag <= 1'b1;
    idle();
    rd(`STATUS_OFS, 8'h04);
    wr(`CTRL_OFS, 8'h08);
    serve(0, 13'h0800);
    chk("global_mask", global_mask, 1'b1);
    chk("stack pcl", mem_m.mem[14'h00ff], 8'hbc);
    chk("stack pch", mem_m.mem[14'h00fe], 8'h0a);
    chk("stack idx", mem_m.mem[14'h00fd], 8'hc3);
    chk("stack acc", mem_m.mem[14'h00fc], 8'h5a);
    chk("stack ccr", mem_m.mem[14'h00fb], 8'h15);
    rd(`SP_OFS, 8'h3a);
    timer_overflow_flag <= 1'b0;
    serve(2, 13'h0abc);
    chk("ctx_restore", ctx_restore, 1'b1);
    chk("ctx_out", ctx_out, cpu_ctx);
    chk("global_mask", global_mask, 1'b0);
    wr(`CTRL_OFS, 8'h10);
    periodic_tick_flag <= 1'b1;
    serve(0, 13'h0800);
    periodic_tick_flag <= 1'b0;
    serve(1, 13'h0500);
    wr(`CTRL_OFS, 8'h0c);
    end_of_cycle_flag <= 1'b1;
    timer_overflow_flag <= 1'b1;
    serve(0, 13'h0700);
    end_of_cycle_flag <= 1'b0;
    wr(`CTRL_OFS, 8'h08);
    serve(0, 13'h0800);
    timer_overflow_flag <= 1'b0;
    wr(`CTRL_OFS, 8'h00);
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    serve(1, 13'h0600);
    rd(`STATUS_OFS, 8'h08);
    serve(0, 13'h0500);
    irq_pin_n <= 1'b1;
    wr(`KEY_EN_OFS, 8'h02);
    rd(`KEY_EN_OFS, 8'h02);
    wr(`CTRL_OFS, 8'h00);
    keyport_pin <= 8'hfe;
    repeat (4) @(posedge sys_clk);
    idle();
    keyport_pin <= 8'hfc;
    repeat (4) @(posedge sys_clk);
    serve(0, 13'h0600);
    chk("line high", branch_if_line_high, 1'b0);
    rd(`LINE_OFS, 8'h00);
    keyport_pin <= 8'hff;
    wr(`CTRL_OFS, 8'h02);
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    idle();
    stop_test();
  end
endmodule : cpu_interrupt_vectoring_bench
